// ---- inc/gsm_pkg.sv ----
package gsm_pkg;
    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_PIN_STATUS_UPPER = 8'h25;
    localparam logic [7:0] IDX_BATTERY_VALUE = 8'h26;
    localparam logic [7:0] IDX_ANALOG_IN_EIGHT_VALUE = 8'h27;
    localparam logic [7:0] IDX_REMOTE_TEMP_ONE_VALUE = 8'h28;
    localparam logic [7:0] IDX_REMOTE_TEMP_TWO_OR_NINE = 8'h29;
    localparam logic [7:0] IDX_STANDBY_RAIL_VALUE = 8'h2a;
    localparam logic [7:0] IDX_MAIN_RAIL_VALUE = 8'h2b;
    localparam logic [7:0] IDX_FIVE_VOLT_VALUE = 8'h2c;
    localparam logic [7:0] IDX_CORE_RAIL_VALUE = 8'h2d;
    localparam logic [7:0] IDX_TWELVE_VOLT_VALUE = 8'h2e;
    localparam logic [7:0] IDX_NEG_TWELVE_VOLT_VALUE = 8'h2f;
    localparam logic [7:0] IDX_PIN_CONFIG_THREE = 8'h08;
    localparam logic [7:0] IDX_PIN_CONFIG_FOUR = 8'h09;
    localparam logic [7:0] IDX_CHANNEL_MODE = 8'h0a;
    // First and last index of the measured-value run.
    localparam logic [7:0] IDX_MEAS_FIRST = IDX_BATTERY_VALUE;
    localparam logic [7:0] IDX_MEAS_LAST = IDX_NEG_TWELVE_VOLT_VALUE;
    localparam int MEAS_COUNT = 10;
    // Slot of the shared remote-two / analog-nine register in the run.
    localparam int SLOT_SHARED = 3;
    // Pin configuration fields: per pin, bit 2k is direction, 2k+1 polarity.
    localparam int CFG_DIR_BIT = 0;
    localparam int CFG_POL_BIT = 1;
    localparam int CHANNEL_MODE_REMOTE_BIT = 0;
    localparam logic [7:0] RESET_PIN_STATUS = 8'h00;
    localparam logic [7:0] RESET_MEAS = 8'h00;
    localparam logic [7:0] RESET_PIN_CONFIG = 8'h00;
    localparam logic [7:0] RESET_CHANNEL_MODE = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLAVEERROR = 2'h2;
endpackage

// ---- rtl/gsm_regbank.sv ----
// How it works
// RULE1: An input-configured pin 8 to 15 sets its status bit while it is asserted.
// RULE2: An output-configured pin is asserted whenever software has set its status bit.
// RULE3: Writes reach a status bit only when its pin is an output; input bits ignore writes.
// RULE4: Polarity of pins 8 to 11 comes from bits 1, 3, 5, 7 of pin configuration three.
// RULE5: Polarity of pins 12 to 15 comes from bits 1, 3, 5, 7 of pin configuration four.
// RULE6: Pin 8 to 15 status sits in bits 0 to 7 at index 25h and resets to 00h.
// RULE7: Indices 26h upward hold one read-only 8-bit measured value each, reset 00h.
// RULE8: Index 28h returns the first remote temperature result, read-only.
// RULE9: Index 29h holds remote temperature two or analog input nine, per a mode bit.
// RULE10: Index 2Ah returns the standby rail and 2Bh the main rail, read-only.
// RULE11: A measured value changes only on that channel's conversion strobe; reads change nothing.
//
// Local design decision: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module gsm_regbank
(
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic [9:0] ADDRESS_I,
    input wire logic READ_I,
    input wire logic WRITE_I,
    input wire logic [31:0] WRITEDATA_I,
    input wire logic [3:0] BYTEENABLE_I,
    output logic [31:0] READDATA_O,
    output logic WAITREQUEST_O,
    output logic [1:0] RESPONSE_O,
    input wire logic [7:0] GP_PIN_I,
    output logic [7:0] GP_PIN_O,
    output logic [7:0] GP_PIN_OE_O,
    input wire logic [9:0] MEAS_VALID_I,
    input wire logic [79:0] MEAS_DATA_I,
    input wire logic ANALOG_NINE_VALID_I,
    input wire logic [7:0] ANALOG_NINE_DATA_I,
    output logic REMOTE_TWO_SEL_O
);
    logic wait_reg;
    logic [31:0] rdata_reg;
    logic [1:0] resp_reg;
    logic [7:0] status_reg;
    logic [7:0] status_next;
    logic [7:0] cfg_three_reg;
    logic [7:0] cfg_four_reg;
    logic [7:0] mode_reg;
    logic [7:0] pin_out_reg;
    logic [7:0] pin_oe_reg;
    logic [7:0] meas_reg [gsm_pkg::MEAS_COUNT];
    logic [7:0] pin_dir;
    logic [7:0] pin_pol;
    logic [7:0] idx;
    logic aligned;
    logic req;
    logic wr_go;
    logic wr_lane0;
    logic hit;
    logic [31:0] rd_mux;
    logic [7:0] slot;
    logic wr_status;
    logic wr_cfg_three;
    logic wr_cfg_four;
    logic wr_mode;

    // The bus carries byte addresses; each register owns one 32-bit word.
    assign idx = ADDRESS_I[9:2];
    // Byte lanes 1 to 3 carry nothing, so only word-aligned addresses decode.
    assign aligned = (ADDRESS_I[1:0] == 2'h0);
    assign req = READ_I | WRITE_I;
    // A write lands on the one edge where the master sees waitrequest low.
    assign wr_go = WRITE_I & ~wait_reg;
    assign wr_lane0 = wr_go & BYTEENABLE_I[0] & aligned;
    assign slot = idx - gsm_pkg::IDX_MEAS_FIRST;
    // Decoded write strobes; a write to any other index is dropped here.
    assign wr_status = wr_lane0 && idx == gsm_pkg::IDX_PIN_STATUS_UPPER;
    assign wr_cfg_three = wr_lane0 && idx == gsm_pkg::IDX_PIN_CONFIG_THREE;
    assign wr_cfg_four = wr_lane0 && idx == gsm_pkg::IDX_PIN_CONFIG_FOUR;
    assign wr_mode = wr_lane0 && idx == gsm_pkg::IDX_CHANNEL_MODE;

    // Unpack direction and polarity for each pin from the two config bytes.
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_cfg
            assign pin_dir[g] = cfg_three_reg[2*g + gsm_pkg::CFG_DIR_BIT];
            assign pin_pol[g] = cfg_three_reg[2*g + gsm_pkg::CFG_POL_BIT]; // RULE4
            assign pin_dir[g+4] = cfg_four_reg[2*g + gsm_pkg::CFG_DIR_BIT];
            assign pin_pol[g+4] = cfg_four_reg[2*g + gsm_pkg::CFG_POL_BIT]; // RULE5
        end
    endgenerate

    // Read mux; anything not decoded here reads as zero and answers an error.
    always_comb
    begin
        hit = 1'b0;
        rd_mux = 32'h0000_0000;
        if (!aligned)
        begin
            hit = 1'b0;
        end
        else if (idx == gsm_pkg::IDX_PIN_STATUS_UPPER)
        begin
            hit = 1'b1;
            rd_mux = {24'h00_0000, status_reg}; // RULE6
        end
        else if (idx >= gsm_pkg::IDX_MEAS_FIRST &&
                 idx <= gsm_pkg::IDX_MEAS_LAST)
        begin
            hit = 1'b1;
            // The range test keeps the slot inside the array.
            rd_mux = {24'h00_0000, meas_reg[slot[3:0]]}; // RULE7 RULE8 RULE10
        end
        else if (idx == gsm_pkg::IDX_PIN_CONFIG_THREE)
        begin
            hit = 1'b1;
            rd_mux = {24'h00_0000, cfg_three_reg};
        end
        else if (idx == gsm_pkg::IDX_PIN_CONFIG_FOUR)
        begin
            hit = 1'b1;
            rd_mux = {24'h00_0000, cfg_four_reg};
        end
        else if (idx == gsm_pkg::IDX_CHANNEL_MODE)
        begin
            hit = 1'b1;
            rd_mux = {24'h00_0000, mode_reg};
        end
    end

    // One wait state: waitrequest drops for one cycle after each request.
    // Holding it high in reset keeps a request made then pending.
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            wait_reg <= 1'b1;
        end
        else if (req && wait_reg)
        begin
            wait_reg <= 1'b0;
        end
        else
        begin
            wait_reg <= 1'b1;
        end
    end

    // Read data is captured as waitrequest drops and then stands.
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            rdata_reg <= 32'h0000_0000;
        end
        else if (req && wait_reg)
        begin
            rdata_reg <= READ_I ? rd_mux : 32'h0000_0000; // RULE11
        end
    end

    // Unmapped or misaligned accesses answer with an error, never a hang.
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            resp_reg <= gsm_pkg::RESP_OKAY;
        end
        else if (req && wait_reg)
        begin
            resp_reg <= hit ? gsm_pkg::RESP_OKAY : gsm_pkg::RESP_SLAVEERROR;
        end
    end

    // Direction and polarity move only on a write, so pin roles are stable.
    // Pins 8 to 11 take their role from the third config register.
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            cfg_three_reg <= gsm_pkg::RESET_PIN_CONFIG;
        end
        else if (wr_cfg_three)
        begin
            cfg_three_reg <= WRITEDATA_I[7:0];
        end
    end

    // Pins 12 to 15 take their role from the fourth config register.
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            cfg_four_reg <= gsm_pkg::RESET_PIN_CONFIG;
        end
        else if (wr_cfg_four)
        begin
            cfg_four_reg <= WRITEDATA_I[7:0];
        end
    end

    // Channel mode picks which converter result lands in the shared slot.
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            mode_reg <= gsm_pkg::RESET_CHANNEL_MODE;
        end
        else if (wr_mode)
        begin
            mode_reg <= WRITEDATA_I[7:0];
        end
    end

    // Input bits track the pin every cycle, so a write to them has no effect.
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (!pin_dir[i])
            begin
                status_next[i] = ~(GP_PIN_I[i] ^ pin_pol[i]); // RULE1 RULE3
            end
            else if (wr_status)
            begin
                status_next[i] = WRITEDATA_I[i]; // RULE3
            end
            else
            begin
                status_next[i] = status_reg[i];
            end
        end
    end

    // The status byte is rewritten every cycle: input bits follow the pins
    // and output bits hold until software writes them.
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            status_reg <= gsm_pkg::RESET_PIN_STATUS; // RULE6
        end
        else
        begin
            status_reg <= status_next;
        end
    end

    // Pin drive follows the next status so it lines up with the register.
    // Polarity bit high means active high.
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            pin_out_reg <= 8'h00;
        end
        else
        begin
            pin_out_reg <= ~(status_next ^ pin_pol); // RULE2
        end
    end

    // Reset leaves every pin undriven; the enable lags a direction write
    // by one edge because it is taken from the config register itself.
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            pin_oe_reg <= 8'h00;
        end
        else
        begin
            pin_oe_reg <= pin_dir;
        end
    end

    // The shared slot takes remote two when the mode bit is set, else nine.
    generate
        for (g = 0; g < gsm_pkg::MEAS_COUNT; g++)
        begin : g_meas
            logic upd;
            logic [7:0] val;
            if (g == gsm_pkg::SLOT_SHARED)
            begin : g_shared
                assign upd = mode_reg[gsm_pkg::CHANNEL_MODE_REMOTE_BIT] ?
                             MEAS_VALID_I[g] : ANALOG_NINE_VALID_I; // RULE9
                assign val = mode_reg[gsm_pkg::CHANNEL_MODE_REMOTE_BIT] ?
                             MEAS_DATA_I[8*g +: 8] : ANALOG_NINE_DATA_I;
            end
            else
            begin : g_plain
                assign upd = MEAS_VALID_I[g];
                assign val = MEAS_DATA_I[8*g +: 8];
            end
            always_ff @(posedge CLK_I)
            begin
                if (RST_I)
                begin
                    meas_reg[g] <= gsm_pkg::RESET_MEAS; // RULE7
                end
                else if (upd)
                begin
                    meas_reg[g] <= val; // RULE11
                end
            end
        end
    endgenerate

    // Every output is a flop; no decode logic sits between it and the pin.
    assign READDATA_O = rdata_reg;
    assign WAITREQUEST_O = wait_reg;
    assign RESPONSE_O = resp_reg;
    assign GP_PIN_O = pin_out_reg;
    assign GP_PIN_OE_O = pin_oe_reg;
    assign REMOTE_TWO_SEL_O = mode_reg[gsm_pkg::CHANNEL_MODE_REMOTE_BIT];
endmodule
`default_nettype wire

// ---- tb/gsm_regbank_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module gsm_regbank_checker
(
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic [9:0] ADDRESS_I,
    input wire logic READ_I,
    input wire logic WRITE_I,
    input wire logic [31:0] READDATA_O,
    input wire logic WAITREQUEST_O,
    input wire logic [1:0] RESPONSE_O,
    input wire logic [7:0] GP_PIN_O,
    input wire logic [7:0] GP_PIN_OE_O,
    input wire logic REMOTE_TWO_SEL_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    wire logic [7:0] idx = ADDRESS_I[9:2];
    wire logic bad = ADDRESS_I[1:0] != 2'h0 ||
        !(idx inside {[8'h08:8'h0a], [8'h25:8'h2f]});
    wire logic req = (READ_I || WRITE_I) && WAITREQUEST_O;
    wire logic done = (READ_I || WRITE_I) && !WAITREQUEST_O;
    AST_WAIT_ANSWER: assert property (req |=> !WAITREQUEST_O)
        else $error("request not answered after one wait cycle");
    AST_WAIT_ONE: assert property (!WAITREQUEST_O |=> WAITREQUEST_O)
        else $error("waitrequest low for more than one cycle");
    AST_UPPER_ZERO: assert property (done |-> READDATA_O[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    AST_UNMAPPED: assert property (READ_I && req && bad |=>
        RESPONSE_O == gsm_pkg::RESP_SLAVEERROR && READDATA_O == 32'h0)
        else $error("unmapped read not refused");
    AST_MAPPED_OK: assert property (req && !bad |=>
        RESPONSE_O == gsm_pkg::RESP_OKAY)
        else $error("mapped access answered with error");
    // Direction bits live in config registers, so only a write may move them.
    // The enable follows the config register one edge after the write.
    AST_OE_BY_WRITE: assert property ($changed(GP_PIN_OE_O) |->
        $past(done, 2) && $past(WRITE_I, 2))
        else $error("pin enable changed without a write");
    AST_PIN_BY_WRITE: assert property
        (|(GP_PIN_OE_O & (GP_PIN_O ^ $past(GP_PIN_O))) |->
        ($past(done) && $past(WRITE_I)) ||
        ($past(done, 2) && $past(WRITE_I, 2)))
        else $error("driven pin changed without a write");
    AST_SEL_BY_WRITE: assert property ($changed(REMOTE_TWO_SEL_O) |->
        $past(done) && $past(WRITE_I) &&
        $past(idx) == gsm_pkg::IDX_CHANNEL_MODE)
        else $error("channel select changed without mode write");
    cover property (done && WRITE_I && idx == gsm_pkg::IDX_PIN_STATUS_UPPER);
    cover property (READ_I && req && bad);
    cover property (GP_PIN_OE_O != 8'h00);
endmodule
bind gsm_regbank gsm_regbank_checker chk (.CLK_I, .RST_I, .ADDRESS_I,
    .READ_I, .WRITE_I, .READDATA_O, .WAITREQUEST_O, .RESPONSE_O,
    .GP_PIN_O, .GP_PIN_OE_O, .REMOTE_TWO_SEL_O);
`default_nettype wire

// ---- tb/gsm_regbank_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module gsm_regbank_bench;
    logic CLK_I, RST_I, READ_I, WRITE_I, WAITREQUEST_O, REMOTE_TWO_SEL_O;
    logic [9:0] ADDRESS_I;
    logic [31:0] WRITEDATA_I, READDATA_O, rdata;
    logic [3:0] BYTEENABLE_I;
    logic [1:0] RESPONSE_O, rresp;
    logic [7:0] GP_PIN_I, GP_PIN_O, GP_PIN_OE_O, ANALOG_NINE_DATA_I;
    logic [9:0] MEAS_VALID_I;
    logic [79:0] MEAS_DATA_I;
    logic ANALOG_NINE_VALID_I;
    int bad_count = 0;
    int total_checks = 0;
    gsm_regbank dut (.CLK_I(CLK_I), .RST_I(RST_I), .ADDRESS_I(ADDRESS_I),
        .READ_I(READ_I), .WRITE_I(WRITE_I), .WRITEDATA_I(WRITEDATA_I),
        .BYTEENABLE_I(BYTEENABLE_I), .READDATA_O(READDATA_O),
        .WAITREQUEST_O(WAITREQUEST_O), .RESPONSE_O(RESPONSE_O),
        .GP_PIN_I(GP_PIN_I), .GP_PIN_O(GP_PIN_O), .GP_PIN_OE_O(GP_PIN_OE_O),
        .MEAS_VALID_I(MEAS_VALID_I), .MEAS_DATA_I(MEAS_DATA_I),
        .ANALOG_NINE_VALID_I(ANALOG_NINE_VALID_I),
        .ANALOG_NINE_DATA_I(ANALOG_NINE_DATA_I),
        .REMOTE_TWO_SEL_O(REMOTE_TWO_SEL_O));
    initial
    begin
        CLK_I = 1'b0;
        forever #25 CLK_I = ~CLK_I;
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // The request is left up so that a following call runs back to back.
    // Only the watchdog ends a wait for the answer.
    task automatic acc(input logic w, input logic [7:0] i,
                       input logic [7:0] d);
        ADDRESS_I <= {i, 2'b00};
        READ_I <= !w;
        WRITE_I <= w;
        WRITEDATA_I <= {24'h0, d};
        do
            @(posedge CLK_I);
        while (WAITREQUEST_O !== 1'b0);
        rdata = READDATA_O;
        rresp = RESPONSE_O;
    endtask
    task automatic idle();
        READ_I <= 1'b0;
        WRITE_I <= 1'b0;
        @(posedge CLK_I);
    endtask
    task automatic rd(input logic [7:0] i, input logic [7:0] exp);
        acc(1'b0, i, 8'h00);
        check(rdata, {24'h0, exp});
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        acc(1'b1, i, d);
        idle();
    endtask
    initial
    begin
        repeat (3000) @(posedge CLK_I);
        bad_count++;
        print_verdict();
    end
    initial
    begin
        RST_I = 1'b1;
        READ_I = 1'b0;
        WRITE_I = 1'b0;
        ADDRESS_I = 10'h000;
        WRITEDATA_I = 32'h0;
        BYTEENABLE_I = 4'h1;
        GP_PIN_I = 8'hff;
        MEAS_VALID_I = 10'h000;
        MEAS_DATA_I = 80'h0;
        ANALOG_NINE_VALID_I = 1'b0;
        ANALOG_NINE_DATA_I = 8'h00;
        repeat (4) @(posedge CLK_I);
        RST_I <= 1'b0;
        @(posedge CLK_I);
        for (int i = 8'h25; i <= 8'h2f; i++)
            rd(8'(i), 8'h00);
        idle();
        $display("reset values done");
        for (int k = 0; k < 10; k++)
            MEAS_DATA_I[8*k +: 8] <= 8'h30 + 8'(k);
        MEAS_VALID_I <= 10'h3f7;
        @(posedge CLK_I);
        MEAS_VALID_I <= 10'h000;
        MEAS_DATA_I <= {10{8'hff}};
        for (int k = 0; k < 10; k++)
            if (k != 3)
                rd(8'h26 + 8'(k), 8'h30 + 8'(k));
        rd(8'h28, 8'h32);
        wr(8'h2a, 8'hff);
        rd(8'h2a, 8'h34);
        rd(8'h2b, 8'h35);
        idle();
        ANALOG_NINE_DATA_I <= 8'h9a;
        ANALOG_NINE_VALID_I <= 1'b1;
        @(posedge CLK_I);
        ANALOG_NINE_VALID_I <= 1'b0;
        rd(8'h29, 8'h9a);
        wr(8'h0a, 8'h01);
        MEAS_DATA_I[31:24] <= 8'h6b;
        MEAS_VALID_I <= 10'h008;
        @(posedge CLK_I);
        MEAS_VALID_I <= 10'h000;
        rd(8'h29, 8'h6b);
        rd(8'h29, 8'h6b);
        check({31'h0, REMOTE_TWO_SEL_O}, 32'h1);
        idle();
        BYTEENABLE_I <= 4'h0;
        wr(8'h0a, 8'h00);
        BYTEENABLE_I <= 4'h1;
        rd(8'h0a, 8'h01);
        check({31'h0, REMOTE_TWO_SEL_O}, 32'h1);
        idle();
        $display("measured values done");
        GP_PIN_I <= 8'h0f;
        idle();
        rd(8'h25, 8'hf0);
        idle();
        wr(8'h08, 8'haa);
        rd(8'h25, 8'hff);
        idle();
        wr(8'h09, 8'h88);
        rd(8'h25, 8'h5f);
        idle();
        wr(8'h25, 8'h00);
        rd(8'h25, 8'h5f);
        idle();
        wr(8'h08, 8'h03);
        wr(8'h25, 8'h00);
        rd(8'h25, 8'h50);
        idle();
        wr(8'h25, 8'h01);
        check({16'h0, GP_PIN_OE_O, 7'h0, GP_PIN_O[0]}, 32'h0101);
        wr(8'h08, 8'h01);
        // A polarity change reaches the pin one edge after the write lands.
        idle();
        check({16'h0, GP_PIN_OE_O, 7'h0, GP_PIN_O[0]}, 32'h0100);
        rd(8'h30, 8'h00);
        check({30'h0, rresp}, 32'h2);
        idle();
        $display("pin status done");
        print_verdict();
    end
endmodule
`default_nettype wire
